// ### hw/adc_readout_pkg.sv
`default_nettype none

package adc_readout_pkg;

  // Result word and frame layout, in serial clock cycles
  localparam int WORD_BITS    = 12;
  localparam int GAP_BITS     = 4;
  localparam int ACQ_CYCLES   = 3;
  localparam int CONV_CYCLES  = 12;
  localparam int FRAME_CYCLES = 32;
  localparam int CNT_W        = $clog2(FRAME_CYCLES);

  // Falling-edge numbers inside one conversion; edge 32 wraps to 0
  localparam logic [CNT_W-1:0] EDGE_FIRST     = CNT_W'(1);
  localparam logic [CNT_W-1:0] EDGE_HOLD      = CNT_W'(ACQ_CYCLES + 1);
  localparam logic [CNT_W-1:0] EDGE_CONV_END  = CNT_W'(ACQ_CYCLES + 1 + CONV_CYCLES);
  localparam logic [CNT_W-1:0] EDGE_A_FIRST   = CNT_W'(GAP_BITS + 1);
  localparam logic [CNT_W-1:0] EDGE_A_LAST    = CNT_W'(GAP_BITS + WORD_BITS);
  localparam logic [CNT_W-1:0] EDGE_B_FIRST   = CNT_W'(2 * GAP_BITS + WORD_BITS + 1);
  localparam logic [CNT_W-1:0] EDGE_FRAME_END = CNT_W'(FRAME_CYCLES);
  localparam logic [CNT_W-1:0] CNT_RESET      = 5'h0;

  // Sample queue in front of the link
  localparam int FIFO_DEPTH = 16;

  // Both channel results of one conversion, two's complement
  typedef struct packed {
    logic [WORD_BITS-1:0] channel_a_diff_input;
    logic [WORD_BITS-1:0] channel_b_diff_input;
  } sample_pair_t;

  localparam int           PAIR_W       = $bits(sample_pair_t);
  localparam sample_pair_t SAMPLE_RESET = 24'h00_0000;

  // Converter phase within one conversion
  typedef enum logic [1:0] {
    PH_TRACK,
    PH_CONVERT,
    PH_SHIFT
  } phase_t;

endpackage

`default_nettype wire

// ### hw/dual_adc_serial_readout.sv
// Operation
// - Both inputs are held on the fourth falling serial clock edge of a frame.
// - Channel A and channel B are held on the very same edge.
// - Held values stay untouched while a conversion runs.
// - One conversion of both channels spans exactly 32 serial clock cycles.
// - Result bits leave on falling serial clock edges, most significant first.
// - Each channel result is a 12-bit two's complement word.
// - Channel A, then four zero bits, then channel B.
// - Bits sent belong to the conversion running in that frame.
// - Chip select held low restarts conversions back to back.
// - Chip select low frames a transfer; data output floats while it is high.
// - Track for three cycles, then convert for twelve.
// - Edges 1-4 zero, 5-16 channel A, 17-20 zero, 21-32 channel B.
// - Tracking resumes at edge 32N+1, conversion at edge 32N+4.

`timescale 1ns/1ps
`default_nettype none

module sample_fifo
  import adc_readout_pkg::*;
#(
  parameter int WIDTH = PAIR_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // System clock and control
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  // Filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign full      = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign empty     = (wr_ptr_q == rd_ptr_q);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full && clk_en;
  assign pop       = out_ready && !empty && clk_en;
  assign out_data  = mem[rd_ptr_q[AW-1:0]];

  // Storage, no reset needed on data
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  // Write pointer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_ptr_q <= '0;
    end else if (push) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_ptr_q <= '0;
    end else if (pop) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  a_fifo_no_overrun: assert property (@(posedge clock) disable iff (sys_rst)
    full && !pop |=> $stable(wr_ptr_q))
    else $error("fifo pointer moved while full");

endmodule // sample_fifo

module dual_adc_serial_readout
  import adc_readout_pkg::*;
(
  // System clock domain
  input  wire logic          clock,
  input  wire logic          sys_rst,
  input  wire logic          clk_en,
  // Quantised channel pair from the converter core
  input  wire logic          sample_valid,
  input  wire sample_pair_t  sample_in,
  output logic               sample_ready,
  output logic               sample_taken,
  // Serial link, host driven clock and select
  input  wire logic          sclk,
  input  wire logic          cs_n,
  output logic               dout_o,
  output logic               dout_oe,
  output logic               converting
);

  // System-domain signals
  logic          link_rst_q;
  logic          q_valid;
  logic          q_ready;
  sample_pair_t  q_data;
  sample_pair_t  mail_q;
  logic          req_q;
  logic          busy_q;
  logic          ack_s1_q;
  logic          ack_s2_q;
  logic          hold_s1_q;
  logic          hold_s2_q;
  logic          hold_s3_q;
  logic          taken_q;

  // Link-domain signals
  logic             req_s1_q;
  logic             req_s2_q;
  logic             ack_q;
  sample_pair_t     track_q;
  sample_pair_t     hold_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] edge_n;
  phase_t           phase_q;
  logic             dout_q;
  logic             fresh_q;
  logic             hold_tgl_q;

  // Serial bit for falling edge n of a conversion
  function automatic logic frame_bit(input logic [CNT_W-1:0] n, input sample_pair_t s);
    logic [CNT_W-1:0] ia;
    logic [CNT_W-1:0] ib;
    ia = EDGE_A_LAST - n;
    ib = EDGE_FRAME_END - n;
    if (n >= EDGE_A_FIRST && n <= EDGE_A_LAST) begin
      return s.channel_a_diff_input[ia[3:0]];
    end else if (n >= EDGE_B_FIRST || n == EDGE_FRAME_END) begin
      return s.channel_b_diff_input[ib[3:0]];
    end
    return 1'b0; // Leading and middle zero gaps
  endfunction

  // Registered copy of reset, used as the link-side asynchronous clear
  always_ff @(posedge clock) begin
    link_rst_q <= sys_rst;
  end

  // Queue the core's sample pairs; back-pressure reaches the core
  sample_fifo #(
    .WIDTH (PAIR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_queue (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_valid  (sample_valid),
    .in_data   (sample_in),
    .in_ready  (sample_ready),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_data)
  );

  // Only drain when the mailbox is free
  assign q_ready = !busy_q;

  // Return acknowledge synchroniser
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else if (clk_en) begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  // Mailbox: word stays stable until the link side toggles back
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mail_q <= SAMPLE_RESET;
      req_q  <= 1'b0;
      busy_q <= 1'b0;
    end else if (clk_en) begin
      if (q_valid && !busy_q) begin
        mail_q <= q_data;
        req_q  <= !req_q;
        busy_q <= 1'b1;
      end else if (busy_q && ack_s2_q == req_q) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Hold event back to the system side as a toggle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hold_s1_q <= 1'b0;
      hold_s2_q <= 1'b0;
      hold_s3_q <= 1'b0;
      taken_q   <= 1'b0;
    end else if (clk_en) begin
      hold_s1_q <= hold_tgl_q;
      hold_s2_q <= hold_s1_q;
      hold_s3_q <= hold_s2_q;
      taken_q   <= hold_s2_q ^ hold_s3_q;
    end
  end

  assign sample_taken = taken_q;

  // Link side: request synchroniser and tracking register
  always_ff @(posedge sclk or posedge link_rst_q) begin
    if (link_rst_q) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      ack_q    <= 1'b0;
      track_q  <= SAMPLE_RESET;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      if (req_s2_q != ack_q) begin
        track_q <= mail_q; // Stable while the request is open
        ack_q   <= req_s2_q;
      end
    end
  end

  // Number of the falling edge now arriving, wraps every conversion
  assign edge_n = cnt_q + EDGE_FIRST;

  // Edge counter, cleared by the frame's own select
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_q <= CNT_RESET;
    end else begin
      cnt_q <= edge_n; // 5-bit wrap gives 32 cycles per conversion
    end
  end

  // Track, convert and shift phases
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      phase_q <= PH_TRACK;
    end else begin
      case (phase_q)
        PH_TRACK: begin
          if (edge_n == EDGE_HOLD) begin
            phase_q <= PH_CONVERT;
          end
        end
        PH_CONVERT: begin
          if (edge_n == EDGE_CONV_END) begin
            phase_q <= PH_SHIFT;
          end
        end
        PH_SHIFT: begin
          if (edge_n == EDGE_FIRST) begin
            phase_q <= PH_TRACK;
          end
        end
        default: begin
          phase_q <= PH_TRACK;
        end
      endcase
    end
  end

  // Both channels frozen together on the hold edge only
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      hold_q  <= SAMPLE_RESET;
      fresh_q <= 1'b0;
    end else if (edge_n == EDGE_HOLD) begin
      hold_q  <= track_q;
      fresh_q <= 1'b1;
    end else if (edge_n == EDGE_FIRST) begin
      fresh_q <= 1'b0; // Old result no longer valid
    end
  end

  // Hold toggle survives frame ends so the crossing never loses an event
  always_ff @(negedge sclk or posedge link_rst_q) begin
    if (link_rst_q) begin
      hold_tgl_q <= 1'b0;
    end else if (!cs_n && edge_n == EDGE_HOLD) begin
      hold_tgl_q <= !hold_tgl_q;
    end
  end

  // Serial data launched on falling edges
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      dout_q <= 1'b0;
    end else begin
      dout_q <= frame_bit(edge_n, hold_q);
    end
  end

  // Select acts as output enable, no clock needed to float the pin
  assign dout_o     = dout_q;
  assign dout_oe    = !cs_n;
  assign converting = (phase_q == PH_CONVERT);

  // Named steps of one conversion
  sequence s_hold_edge;
    cnt_q == EDGE_HOLD;
  endsequence

  sequence s_a_msbs;
    dout_q == hold_q.channel_a_diff_input[11] ##1 dout_q == hold_q.channel_a_diff_input[10];
  endsequence

  property p_msb_first;
    @(negedge sclk) disable iff (cs_n)
      s_hold_edge |=> s_a_msbs;
  endproperty

  a_hold_edge: assert property (@(negedge sclk) disable iff (cs_n)
    s_hold_edge |-> phase_q == PH_CONVERT && fresh_q)
    else $error("hold edge did not start conversion");

  a_pair_same_edge: assert property (@(negedge sclk) disable iff (cs_n)
    $changed(hold_q) |-> cnt_q == EDGE_HOLD || (cnt_q == CNT_RESET && phase_q == PH_TRACK))
    else $error("held channel changed off the hold edge");

  a_held_isolated: assert property (@(negedge sclk) disable iff (cs_n)
    phase_q != PH_TRACK && cnt_q != EDGE_HOLD |-> $stable(hold_q))
    else $error("held pair moved during conversion");

  a_frame_period: assert property (@(negedge sclk) disable iff (cs_n)
    cnt_q == EDGE_FIRST |-> ##32 cnt_q == EDGE_FIRST)
    else $error("conversion not 32 cycles long");

  a_msb_first: assert property (p_msb_first)
    else $error("channel A not sent msb first");

  a_zero_gaps: assert property (@(negedge sclk) disable iff (cs_n)
    (cnt_q >= EDGE_FIRST && cnt_q <= EDGE_HOLD) || (cnt_q > EDGE_A_LAST && cnt_q < EDGE_B_FIRST) |-> !dout_q)
    else $error("gap bit not zero");

  a_b_word_order: assert property (@(negedge sclk) disable iff (cs_n)
    cnt_q == EDGE_B_FIRST |-> dout_q == hold_q.channel_b_diff_input[11] ##11 dout_q == hold_q.channel_b_diff_input[0])
    else $error("channel B bits misplaced");

  a_current_conv: assert property (@(negedge sclk) disable iff (cs_n)
    cnt_q >= EDGE_A_FIRST || (cnt_q == EDGE_FRAME_END && phase_q == PH_SHIFT) |-> fresh_q)
    else $error("data from a stale conversion");

  a_track_window: assert property (@(negedge sclk) disable iff (cs_n)
    cnt_q == EDGE_FIRST |-> phase_q == PH_TRACK [*3] ##1 phase_q == PH_CONVERT)
    else $error("track window not three cycles");

  a_mail_stable: assert property (@(posedge clock) disable iff (sys_rst)
    busy_q && clk_en && !(ack_s2_q == req_q) |=> $stable(mail_q))
    else $error("mailbox changed while request open");

endmodule // dual_adc_serial_readout

`default_nettype wire

// ### verification/host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  // Frame request from the bench
  input  wire logic  go,
  // Link pins
  input  wire logic  dout,
  output logic       sclk,
  output logic       cs_n,
  // Captured conversions
  output logic [31:0] conv_bits,
  output logic [7:0]  conv_count
);
  // Clock idles high, stands still between frames; uneven duty on purpose
  initial begin
    sclk       = 1'b1;
    cs_n       = 1'b1;
    conv_bits  = 32'h0000_0000;
    conv_count = 8'h00;
    forever begin
      wait (go);
      #30 cs_n = 1'b0;
      #60;
      do begin
        repeat (32) begin
          #60 sclk = 1'b0;
          #100 sclk = 1'b1;
          conv_bits = {conv_bits[30:0], dout};
        end
        conv_count = conv_count + 8'h01;
      end while (go);
      #40 cs_n = 1'b1;
    end
  end
endmodule // host_link_model
`default_nettype wire

// ### verification/tb_dual_adc_serial_readout.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_adc_serial_readout;
  import adc_readout_pkg::*;
  logic         clock, sys_rst, clk_en, sample_valid, sample_ready, sample_taken;
  logic         sclk, cs_n, dout_o, dout_oe, converting, go;
  sample_pair_t sample_in;
  logic [31:0]  conv_bits;
  logic [7:0]   conv_count;
  int           err_total, checks_done, taken_cnt, rk, cyc, acc;
  sample_pair_t exp_q[$];
  sample_pair_t rows[4] = '{24'h7FF_800, 24'h000_FFF, 24'hA5A_5A5, 24'h001_800};
  // Frame each row should give: zeros, A, zeros, B
  logic [31:0]  rows_exp[4] = '{32'h07FF_0800, 32'h0000_0FFF, 32'h0A5A_05A5, 32'h0001_0800};

  dual_adc_serial_readout i_dut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .sample_valid(sample_valid), .sample_in(sample_in), .sample_ready(sample_ready),
    .sample_taken(sample_taken), .sclk(sclk), .cs_n(cs_n), .dout_o(dout_o),
    .dout_oe(dout_oe), .converting(converting));
  // Host sees a pulled-up line whenever the pin is released
  host_link_model i_host (.go(go), .dout(dout_oe ? dout_o : 1'b1), .sclk(sclk), .cs_n(cs_n),
    .conv_bits(conv_bits), .conv_count(conv_count));

  // System clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("counts: %0d checks, %0d mismatches", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [31:0] frame_bits(sample_pair_t p);
    return {4'h0, p.channel_a_diff_input, 4'h0, p.channel_b_diff_input};
  endfunction

  // Offer one pair; ready is looked at on the falling edge where it is settled
  task automatic push(input sample_pair_t p);
    @(negedge clock);
    sample_in    = p;
    sample_valid = 1'b1;
    while (sample_ready !== 1'b1) @(negedge clock);
    @(negedge clock);
    sample_valid = 1'b0;
  endtask

  // Run n conversions in one frame, comparing against queued pairs
  task automatic frame(input int n);
    int t0;
    t0 = taken_cnt;
    go = 1'b1;
    wait (!cs_n);
    for (int k = 0; k < n; k++) begin
      if (k == n - 1) go = 1'b0;
      @(conv_count);
      if (exp_q.size() > 0) check("frame", frame_bits(exp_q.pop_front()), conv_bits);
    end
    wait (cs_n);
    repeat (10) @(posedge clock);
    check("taken", 32'(n), 32'(taken_cnt - t0));
  endtask

  // Hold pulses, cycle ceiling
  always @(posedge clock) begin
    if (sample_taken === 1'b1) taken_cnt++;
    cyc++;
    if (cyc == 12000) begin
      err_total++;
      $display("BAD timeout expected done seen hang");
      complete_run();
    end
  end

  // Per-bit link checks while selected
  always @(negedge cs_n) rk = 0;
  always @(posedge sclk) begin
    rk++;
    if (cs_n === 1'b0) begin // Clock settling at time zero is no frame
      check("oe", 32'h1, 32'(dout_oe));
      check("converting", 32'(((rk - 1) % 32) inside {[3:14]}), 32'(converting));
    end
  end
  // Output released after deselect
  always @(posedge cs_n) begin
    #1;
    check("oe idle", 32'h0, {dout_oe, dout_o});
  end

  // Main sequence
  initial begin
    err_total = 0; checks_done = 0; taken_cnt = 0; cyc = 0; rk = 0; acc = 0;
    sys_rst = 1'b1; clk_en = 1'b1; sample_valid = 1'b0; sample_in = SAMPLE_RESET; go = 1'b0;
    repeat (6) @(negedge clock);
    check("ready rst", 32'h1, {sample_taken, sample_ready});
    check("oe rst", 32'h0, 32'(dout_oe));
    sys_rst = 1'b0;
    $display("test reset done");
    // Ordinary pairs: warm frame already holds the pair, second frame is checked
    foreach (rows[i]) begin
      push(rows[i]);
      frame(1);
      frame(1);
      check("row frame", rows_exp[i], conv_bits);
    end
    $display("test rows done");
    // Back to back conversions, new pair arrives mid-frame
    push(rows[2]);
    frame(1);
    exp_q = '{rows[2], rows[3], rows[3]};
    fork
      frame(3);
      begin
        @(posedge sample_taken);
        push(rows[3]);
      end
    join
    $display("test continuous done");
    // Fill queue with link stopped until refused, then drain
    for (int i = 0; i < 30; i++) begin
      @(negedge clock);
      sample_valid = 1'b1;
      if (sample_ready === 1'b1) begin
        sample_in = {12'(acc), ~12'(acc)};
        acc++;
      end
    end
    @(negedge clock);
    sample_valid = 1'b0;
    check("accepted", 32'd17, 32'(acc));
    frame(4);
    check("drained", {4'h0, 12'h010, 4'h0, ~12'h010}, conv_bits);
    check("ready", 32'h1, 32'(sample_ready));
    $display("test fill done");
    // Enable low: an offered pair must not reach the queue or the link
    @(negedge clock);
    clk_en       = 1'b0;
    sample_in    = rows[0];
    sample_valid = 1'b1;
    repeat (5) @(negedge clock);
    sample_valid = 1'b0;
    clk_en       = 1'b1;
    repeat (5) @(negedge clock);
    frame(1);
    check("frozen", {4'h0, 12'h010, 4'h0, ~12'h010}, conv_bits);
    $display("test enable done");
    complete_run();
  end
endmodule // tb_dual_adc_serial_readout
`default_nettype wire
